/* File: hdl/scs_pkg.sv */
package scs_pkg;
   // clock rate
   localparam int CLK_MHZ = 250;
   // timing figures in their own units
   localparam int LOCK_ON_MS       = 2000;
   localparam int LOCK_OFF_MS      = 5000;
   localparam int STANDBY_US       = 500;
   localparam int MIN_PULSE_US     = 6;
   localparam int OCL_OFF_US       = 25;
   localparam int FORCE_GND_MS     = 100;
   localparam int FORCE_VBB_MS     = 50;
   localparam int FORCE_OPEN_MS    = 200;
   localparam int BLANK_NS         = 2000;
   // derived cycle counts
   localparam int STANDBY_CYC   = STANDBY_US * CLK_MHZ;
   localparam int MIN_PULSE_CYC = MIN_PULSE_US * CLK_MHZ;
   localparam int OCL_OFF_CYC   = OCL_OFF_US * CLK_MHZ;
   localparam int BLANK_CYC     = BLANK_NS * CLK_MHZ / 1000;
   localparam longint LOCK_ON_CYC   = longint'(LOCK_ON_MS) * 1000 * CLK_MHZ;
   localparam longint LOCK_OFF_CYC  = longint'(LOCK_OFF_MS) * 1000 * CLK_MHZ;
   localparam longint FORCE_GND_CYC = longint'(FORCE_GND_MS) * 1000 * CLK_MHZ;
   localparam longint FORCE_VBB_CYC = longint'(FORCE_VBB_MS) * 1000 * CLK_MHZ;
   localparam longint FORCE_OPN_CYC = longint'(FORCE_OPEN_MS) * 1000 * CLK_MHZ;
   // startup handover count
   localparam logic [6:0] STARTUP_ZC_COUNT = 7'h60;
   localparam int STEPS = 6;
   // forced-period select codes
   localparam logic [1:0] SEL_GND  = 2'h0;
   localparam logic [1:0] SEL_VBB  = 2'h1;
   localparam logic [1:0] SEL_OPEN = 2'h2;
   // operating states, gray along usual path
   typedef enum logic [2:0] {
      SCS_IDLE    = 3'h0,
      SCS_START   = 3'h1,
      SCS_RUN     = 3'h3,
      SCS_LOCKOFF = 3'h2,
      SCS_STANDBY = 3'h6
   } scs_mode_e;
endpackage

/* File: hdl/scs_sync.sv */
`timescale 1ns/100ps
module scs_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // pin in, filtered level out
   input  wire logic pin_in,
   output logic      level_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } scs_sync_s;
   scs_sync_s st_reg;
   scs_sync_s st_next;

   // shift chain, level changes when stages two and three agree
   always_comb begin
      st_next     = st_reg;
      st_next.s1  = pin_in;
      st_next.s2  = st_reg.s1;
      st_next.s3  = st_reg.s2;
      if (st_reg.s2 == st_reg.s3) begin
         st_next.lvl = st_reg.s3;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_out = st_reg.lvl;
endmodule

/* File: hdl/scs_sequencer.sv */
// Functional notes
// R01: six-state commutation sequencer drives three half-bridges.
// R02: one output floats per state; back-EMF sensed on it.
// R03: zero cross is floating winding versus centre tap polarity change.
// R04: zero-cross flag rises at crossing, falls at next commutation.
// R05: only first correct-polarity crossing per state is latched.
// R06: detector blanked at start of every commutation.
// R07: step starts on delay-done pulse or forced pulse at startup.
// R08: delay expiry pulses delay-done, advances state, starts blanking.
// R09: crossing after blanking sets flag and starts delay timer.
// R10: startup stepped by internal oscillator until sensing takes over.
// R11: full duty until 96 zero-cross flag pulses counted.
// R12: PWM low 500 us enters standby, outputs disabled.
// R13: no speed indication 2 s: outputs off 5 s, then restart.
// R14: speed output is open drain: pulls low or releases.
// R15: PWM duty reproduced as average drive duty.
// R16: forced interval: ground 100 ms, supply 50 ms, open 200 ms.
// R17: tiny PWM pulses stretched to 6 us minimum.
// R18: overcurrent disables drivers for 25 us.
// R19: commutation delay is half the crossing-to-crossing interval.
// R20: speed output toggles once per detected crossing.
`timescale 1ns/100ps
module scs_sequencer
   import scs_pkg::*;
#(
   parameter longint LOCK_ON_P   = LOCK_ON_CYC,
   parameter longint LOCK_OFF_P  = LOCK_OFF_CYC,
   parameter longint FORCE_GND_P = FORCE_GND_CYC,
   parameter longint FORCE_VBB_P = FORCE_VBB_CYC,
   parameter longint FORCE_OPN_P = FORCE_OPN_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control pins
   input  wire logic       pwm_in,
   input  wire logic [1:0] startup_period_select,
   input  wire logic       overcurrent_in,
   // comparators: phase above centre_tap_input
   input  wire logic [2:0] phase_above_centre_tap_input,
   // half-bridge controls
   output logic [2:0]      high_on,
   output logic [2:0]      low_on,
   // speed_tach_output open drain
   output logic            speed_tach_out,
   output logic            speed_tach_oe,
   // observation
   output logic            zero_cross_flag,
   output logic            delay_done_pulse,
   output logic            forced_commutation_pulse
);
   typedef struct packed {
      scs_mode_e   mode;
      logic [2:0]  step;
      logic        zc;
      logic        blank;
      logic [15:0] blank_cnt;
      logic        delay_run;
      logic [39:0] delay_cnt;
      logic [39:0] period_cnt;
      logic [39:0] last_period;
      logic [39:0] tmr;
      logic [39:0] lock_cnt;
      logic [6:0]  zc_count;
      logic [19:0] low_cnt;
      logic [15:0] stretch;
      logic        pwm_d;
      logic [15:0] ocl_cnt;
      logic        tach;
      logic        dd;
      logic        fc;
      logic [2:0]  hi;
      logic [2:0]  lo;
   } scs_state_s;
   scs_state_s st_reg;
   scs_state_s st_next;

   logic [2:0] cmp;
   logic       pwm_s;
   logic       ocl_s;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   scs_sync u_sync_pwm (
      .clk       (clk),
      .rst_n     (rst_n),
      .pin_in    (pwm_in),
      .level_out (pwm_s)
   );
   scs_sync u_sync_ocl (
      .clk       (clk),
      .rst_n     (rst_n),
      .pin_in    (overcurrent_in),
      .level_out (ocl_s)
   );
   for (genvar g = 0; g < 3; g++) begin : g_cmp
      scs_sync u_sync_cmp (
         .clk       (clk),
         .rst_n     (rst_n),
         .pin_in    (phase_above_centre_tap_input[g]),
         .level_out (cmp[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // per-step helpers
   function automatic logic [1:0] float_phase(input logic [2:0] s);
      case (s)
         3'h0, 3'h3: float_phase = 2'h2;
         3'h1, 3'h4: float_phase = 2'h1;
         default:    float_phase = 2'h0;
      endcase
   endfunction
   // rising crossing expected on even steps
   function automatic logic rising_exp(input logic [2:0] s);
      rising_exp = ~s[0];
   endfunction

   logic [39:0] force_per;
   logic [2:0]  hi_pat;
   logic [2:0]  lo_pat;
   logic        zc_hit;
   logic        step_now;
   logic        drive_en;
   logic        pwm_gate;

   // forced period select, see R16
   always_comb begin
      case (startup_period_select)
         SEL_GND: force_per = 40'(FORCE_GND_P);
         SEL_VBB: force_per = 40'(FORCE_VBB_P);
         default: force_per = 40'(FORCE_OPN_P);
      endcase
   end

   // drive patterns, one floating output per step, see R01 see R02
   always_comb begin
      case (st_reg.step)
         3'h0: begin hi_pat = 3'b001; lo_pat = 3'b010; end
         3'h1: begin hi_pat = 3'b001; lo_pat = 3'b100; end
         3'h2: begin hi_pat = 3'b010; lo_pat = 3'b100; end
         3'h3: begin hi_pat = 3'b010; lo_pat = 3'b001; end
         3'h4: begin hi_pat = 3'b100; lo_pat = 3'b001; end
         default: begin hi_pat = 3'b100; lo_pat = 3'b010; end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      st_next     = st_reg;
      st_next.dd  = 1'b0;
      st_next.fc  = 1'b0;
      // first correct-polarity crossing after blank, see R03 see R05
      zc_hit = (st_reg.mode inside {SCS_START, SCS_RUN}) && !st_reg.blank
               && !st_reg.zc
               && (cmp[float_phase(st_reg.step)] == rising_exp(st_reg.step));
      step_now = 1'b0;
      // period measurement
      st_next.period_cnt = st_reg.period_cnt + 40'h1;
      if (zc_hit) begin
         st_next.zc          = 1'b1; // see R04 see R09
         st_next.last_period = st_reg.period_cnt;
         st_next.period_cnt  = '0;
         st_next.delay_run   = 1'b1; // see R09
         st_next.delay_cnt   = st_reg.period_cnt >> 1; // see R19
         st_next.tach        = ~st_reg.tach; // see R20
         st_next.lock_cnt    = '0;
         if (st_reg.zc_count != STARTUP_ZC_COUNT) begin
            st_next.zc_count = st_reg.zc_count + 7'h1; // see R11
         end
      end
      // blanking timer, see R06
      if (st_reg.blank) begin
         if (st_reg.blank_cnt == 16'h0) begin
            st_next.blank = 1'b0;
         end else begin
            st_next.blank_cnt = st_reg.blank_cnt - 16'h1;
         end
      end
      // commutation delay timer, see R08
      if (st_reg.delay_run && st_reg.mode == SCS_RUN) begin
         if (st_reg.delay_cnt == 40'h0) begin
            st_next.delay_run = 1'b0;
            st_next.dd        = 1'b1;
            step_now          = 1'b1; // see R07
         end else begin
            st_next.delay_cnt = st_reg.delay_cnt - 40'h1;
         end
      end
      // mode machine
      case (st_reg.mode)
         SCS_IDLE: begin
            st_next.mode = SCS_START;
            st_next.tmr  = '0;
         end
         SCS_START: begin
            // oscillator stepping; a crossing beats a forced step, see R10
            if (st_reg.zc && st_reg.delay_run) begin
               st_next.mode = SCS_RUN;
            end else if (st_reg.tmr >= force_per - 40'h1 && !zc_hit) begin
               st_next.tmr = '0;
               st_next.fc  = 1'b1;
               step_now    = 1'b1; // see R07
            end else begin
               st_next.tmr = st_reg.tmr + 40'h1;
            end
         end
         SCS_RUN: begin
         end
         SCS_LOCKOFF: begin
            // off time then restart, see R13
            if (st_reg.tmr >= 40'(LOCK_OFF_P)) begin
               st_next.mode     = SCS_IDLE;
               st_next.lock_cnt = '0;
            end else begin
               st_next.tmr = st_reg.tmr + 40'h1;
            end
         end
         SCS_STANDBY: begin
            if (pwm_s) begin
               st_next.mode     = SCS_IDLE;
               st_next.lock_cnt = '0;
            end
         end
         default: st_next.mode = SCS_IDLE;
      endcase
      // commutation step, see R04 see R06 see R08
      if (step_now) begin
         st_next.step      = (st_reg.step == 3'(STEPS - 1)) ? 3'h0
                             : st_reg.step + 3'h1;
         st_next.zc        = 1'b0;
         st_next.blank     = 1'b1;
         st_next.blank_cnt = 16'(BLANK_CYC - 1);
      end
      // lock detect, see R13
      if (st_reg.mode inside {SCS_START, SCS_RUN} && !zc_hit) begin
         if (st_reg.lock_cnt >= 40'(LOCK_ON_P)) begin
            st_next.mode      = SCS_LOCKOFF;
            st_next.tmr       = '0;
            st_next.delay_run = 1'b0;
            st_next.zc_count  = '0;
            st_next.zc        = 1'b0;
         end else begin
            st_next.lock_cnt = st_reg.lock_cnt + 40'h1;
         end
      end
      // standby on long low PWM, see R12
      if (pwm_s) begin
         st_next.low_cnt = '0;
      end else if (st_reg.low_cnt >= 20'(STANDBY_CYC - 1)) begin
         st_next.mode      = SCS_STANDBY;
         st_next.delay_run = 1'b0;
         st_next.zc_count  = '0;
         st_next.zc        = 1'b0;
      end else begin
         st_next.low_cnt = st_reg.low_cnt + 20'h1;
      end
      // minimum width window opened by each pwm rise, see R17
      st_next.pwm_d = pwm_s;
      if (pwm_s && !st_reg.pwm_d) begin
         st_next.stretch = 16'(MIN_PULSE_CYC - 1);
      end else if (st_reg.stretch != 16'h0) begin
         st_next.stretch = st_reg.stretch - 16'h1;
      end
      // overcurrent off time, see R18
      if (ocl_s && st_reg.ocl_cnt == 16'h0) begin
         st_next.ocl_cnt = 16'(OCL_OFF_CYC);
      end else if (st_reg.ocl_cnt != 16'h0) begin
         st_next.ocl_cnt = st_reg.ocl_cnt - 16'h1;
      end
      // output drive, see R11 see R15
      pwm_gate = (st_reg.zc_count != STARTUP_ZC_COUNT) || pwm_s
                 || (st_reg.stretch != 16'h0);
      drive_en = (st_reg.mode inside {SCS_START, SCS_RUN})
                 && st_reg.ocl_cnt == 16'h0 && pwm_gate;
      st_next.hi = drive_en ? hi_pat : 3'h0;
      st_next.lo = drive_en ? lo_pat : 3'h0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg      <= '0;
         st_reg.mode <= SCS_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from flops, speed_tach_out tied low
   assign high_on                  = st_reg.hi;
   assign low_on                   = st_reg.lo;
   assign speed_tach_out           = 1'b0; // see R14
   assign speed_tach_oe            = st_reg.tach;
   assign zero_cross_flag          = st_reg.zc;
   assign delay_done_pulse         = st_reg.dd;
   assign forced_commutation_pulse = st_reg.fc;

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_step;
      delay_done_pulse || forced_commutation_pulse;
   endsequence
   AST_SIX: assert property (@(posedge clk) disable iff (!rst_n) // see R01
      st_reg.step < 3'h6) else $error("step out of range");
   AST_FLOAT: assert property (@(posedge clk) disable iff (!rst_n) // see R02
      (high_on & low_on) == 3'h0 && $countones(high_on | low_on) != 3)
      else $error("no floating phase");
   AST_ZC_CLR: assert property (@(posedge clk) disable iff (!rst_n) // see R04
      $rose(st_reg.blank) |-> !zero_cross_flag) else $error("flag kept");
   AST_LATCH: assert property (@(posedge clk) disable iff (!rst_n) // see R05
      zero_cross_flag && !$rose(st_reg.blank) |=> zero_cross_flag
      || $rose(st_reg.blank) || st_reg.mode != SCS_RUN)
      else $error("flag dropped mid state");
   AST_BLANK: assert property (@(posedge clk) disable iff (!rst_n) // see R06
      s_step |-> st_reg.blank) else $error("no blank on step");
   AST_DD: assert property (@(posedge clk) disable iff (!rst_n) // see R08
      delay_done_pulse |=> !delay_done_pulse) else $error("dd not pulse");
   AST_DELAY: assert property (@(posedge clk) disable iff (!rst_n) // see R09
      $rose(zero_cross_flag) |-> st_reg.delay_run)
      else $error("delay not started");
   AST_FULL: assert property (@(posedge clk) disable iff (!rst_n) // see R11
      st_reg.zc_count != STARTUP_ZC_COUNT && st_reg.mode == SCS_RUN
      && st_reg.ocl_cnt == 16'h0 |=> (high_on | low_on) != 3'h0)
      else $error("not full duty");
   AST_STBY: assert property (@(posedge clk) disable iff (!rst_n) // see R12
      st_reg.mode == SCS_STANDBY |=> high_on == 3'h0)
      else $error("driving in standby");
   AST_OCL: assert property (@(posedge clk) disable iff (!rst_n) // see R18
      st_reg.ocl_cnt != 16'h0 |=> high_on == 3'h0)
      else $error("driving in overcurrent");
   AST_PW: assert property (@(posedge clk) disable iff (!rst_n) // see R17
      st_reg.stretch != 16'h0 && st_reg.mode == SCS_RUN
      && st_reg.ocl_cnt == 16'h0 |=> high_on != 3'h0)
      else $error("pulse not stretched");
endmodule

/* File: testbench/scs_motor_model.sv */
`timescale 1ns/100ps
module scs_motor_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // half-bridge drive from the sequencer
   input  wire logic [2:0]  high_on,
   input  wire logic [2:0]  low_on,
   // spin control from the bench
   input  wire logic        spin,
   input  wire logic        glitch,
   input  wire logic [15:0] cross_dly,
   // comparators toward the sequencer
   output logic [2:0]       phase_above_centre_tap_input
);
   logic [2:0]  idle_ph;
   logic [2:0]  last_idle;
   logic [15:0] age;
   logic        one_idle;
   // a phase floats when neither switch of it is on
   assign idle_ph  = ~(high_on | low_on);
   assign one_idle = $countones(idle_ph) == 1;
   // floating winding swings past the centre tap once per step
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_above_centre_tap_input <= 3'h2;
         last_idle        <= 3'h0;
         age              <= 16'h0;
      end else begin
         if (one_idle && idle_ph != last_idle) begin
            last_idle <= idle_ph;
            age       <= 16'h0;
         end else begin
            age <= age + 16'h1;
         end
         if (one_idle && spin) begin
            if (age == cross_dly)
               phase_above_centre_tap_input <= phase_above_centre_tap_input ^ idle_ph;
            // short switching transient, back again after 50 cycles
            if (glitch && (age == 16'h64 || age == 16'h96))
               phase_above_centre_tap_input <= phase_above_centre_tap_input ^ idle_ph;
         end
      end
   end
endmodule

/* File: testbench/scs_sequencer_bench.sv */
`timescale 1ns/100ps
module scs_sequencer_bench;
   import scs_pkg::*;
   localparam longint F_GND = 1600;
   localparam longint F_VBB = 800;
   localparam longint F_OPN = 3200;
   localparam longint L_ON  = 12000;
   localparam longint L_OFF = 10000;
   localparam int     DLY   = 600;
   logic       clk, rst_n, pwm_in, overcurrent_in, spin, glitch, mon_on;
   logic [1:0] startup_period_select;
   logic [2:0] phase_above_centre_tap_input, high_on, low_on;
   logic       speed_tach_out, speed_tach_oe, zero_cross_flag;
   logic       delay_done_pulse, forced_commutation_pulse, flag_d, oe_d;
   logic [5:0] pat [0:23];
   int         n_errors, n_compared, cyc, last_rise, n_rise, n_tog;
   int         t0, t1, td, tp, tq;
   scs_sequencer #(.LOCK_ON_P(L_ON), .LOCK_OFF_P(L_OFF),
      .FORCE_GND_P(F_GND), .FORCE_VBB_P(F_VBB), .FORCE_OPN_P(F_OPN))
   scs_sequencer_inst (.clk(clk), .rst_n(rst_n), .pwm_in(pwm_in),
      .startup_period_select(startup_period_select),
      .overcurrent_in(overcurrent_in), .phase_above_centre_tap_input(phase_above_centre_tap_input),
      .high_on(high_on), .low_on(low_on), .speed_tach_out(speed_tach_out),
      .speed_tach_oe(speed_tach_oe), .zero_cross_flag(zero_cross_flag),
      .delay_done_pulse(delay_done_pulse),
      .forced_commutation_pulse(forced_commutation_pulse));
   scs_motor_model scs_motor_model_inst (.clk(clk), .rst_n(rst_n),
      .high_on(high_on), .low_on(low_on), .spin(spin), .glitch(glitch),
      .cross_dly(16'(DLY)), .phase_above_centre_tap_input(phase_above_centre_tap_input));
   ///////////////////////////////////////////////////////////////////////
   // clock, cycle count and hang cut-off
   initial clk = 1'b0;
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 98000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic check(input logic [31:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   function automatic int near(int v, int e, int tol);
      return (v >= e - tol && v <= e + tol) ? e : v;
   endfunction
   function automatic logic hit(int w);
      case (w)
         0: return forced_commutation_pulse;
         1: return delay_done_pulse;
         2: return zero_cross_flag;
         3: return (high_on | low_on) == 3'h0;
         default: return (high_on | low_on) != 3'h0;
      endcase
   endfunction
   // wait, bounded, for an event picked by hit
   task automatic wait_on(input int w, output int t);
      int i;
      for (i = 0; i < 40000; i++) begin
         @(negedge clk);
         if (hit(w) === 1'b1) break;
      end
      t = cyc;
      check(i < 40000, 1'b1, "event missing");
   endtask
   task automatic do_reset(input logic [1:0] sel, input logic sp);
      @(posedge clk);
      rst_n <= 1'b0;
      mon_on <= 1'b0;
      startup_period_select <= sel;
      spin <= sp;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   ///////////////////////////////////////////////////////////////////////
   // watchers: open-drain tach, one floating phase, tach edge counts
   always @(negedge clk) begin
      flag_d <= zero_cross_flag;
      oe_d   <= speed_tach_oe;
      if (rst_n) begin
         check(speed_tach_out, 1'b0, "tach drives high");
         if (zero_cross_flag && !flag_d) begin
            n_rise++;
            last_rise = cyc;
         end
         if (speed_tach_oe !== oe_d) n_tog++;
      end
      if (rst_n && mon_on) begin
         check(high_on & low_on, 3'h0, "shoot-through");
         check($countones(~(high_on | low_on)), 1, "float count");
      end
   end
   ///////////////////////////////////////////////////////////////////////
   // stalled rotor: forced steps at the selected period, code 3 is open
   task automatic t_forced();
      longint per;
      for (int s = 0; s < 4; s++) begin
         per = (s == 0) ? F_GND : (s == 1) ? F_VBB : F_OPN;
         do_reset(2'(s), 1'b0);
         wait_on(0, t0);
         mon_on <= 1'b1;
         wait_on(0, t1);
         check(near(t1 - t0, int'(per), 1), int'(per), "force period");
      end
   endtask
   // sensed running: flag, blanking, delay, six-state order, low pwm
   task automatic t_run();
      do_reset(2'h1, 1'b1);
      wait_on(2, t0);
      mon_on <= 1'b1;
      n_rise = 0;
      n_tog  = 0;
      tp     = t0;
      tq     = t0;
      for (int i = 0; i < 24; i++) begin
         wait_on(1, td);
         @(negedge clk);
         check(zero_cross_flag, 1'b0, "flag after step");
         @(posedge clk);
         glitch <= (i % 5 == 2);
         pwm_in <= !(i >= 4 && i < 12);
         wait_on(2, t1);
         check(near(t1 - td - 6, DLY, 8), DLY, "crossing time");
         pat[i] = {high_on, low_on};
         if (i >= 6) begin
            check(pat[i], pat[i - 6], "six-step cycle");
            check(pat[i] != pat[i - 1] && pat[i] != pat[i - 3], 1'b1,
                  "state distinct");
         end
         if (i >= 1)
            check(near(td - tp, (tp - tq) / 2, 2), (tp - tq) / 2,
                  "delay vs half interval");
         tq = tp;
         tp = t1;
      end
      check(n_tog, n_rise, "tach toggles");
      glitch <= 1'b0;
   endtask
   // overcurrent trip mid-run
   task automatic t_ocp();
      wait_on(2, t0);
      @(posedge clk);
      mon_on <= 1'b0;
      overcurrent_in <= 1'b1;
      repeat (4) @(posedge clk);
      overcurrent_in <= 1'b0;
      wait_on(3, t0);
      wait_on(4, t1);
      check(near(t1 - t0, OCL_OFF_CYC, 8), OCL_OFF_CYC, "ocp off");
   endtask
   // rotor stops: lock off time, then restart
   task automatic t_lock();
      repeat (3) wait_on(2, t0);
      @(posedge clk);
      spin <= 1'b0;
      mon_on <= 1'b0;
      wait_on(3, t0);
      check(near(t0 - last_rise, int'(L_ON), 40), int'(L_ON), "lock on");
      wait_on(4, t1);
      check(near(t1 - t0, int'(L_OFF), 8), int'(L_OFF), "lock off");
   endtask
   ///////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      pwm_in = 1'b1;
      overcurrent_in = 1'b0;
      spin = 1'b0;
      glitch = 1'b0;
      mon_on = 1'b0;
      startup_period_select = 2'h1;
      n_errors = 0;
      n_compared = 0;
      cyc = 0;
      t_forced();
      t_run();
      t_ocp();
      t_lock();
      close_out();
   end
endmodule
